//--- pci_arb_consts.svh
// Register offsets, field positions, reset values and counts for the PCI arbiter
`ifndef PCI_ARB_CONSTS_SVH
`define PCI_ARB_CONSTS_SVH
`define ARB_POLICY_OFS 12'h044
`define ARB_CTRL_OFS 12'h048
`define ARB_STATUS_OFS 12'h04C
`define ARB_TDATA_OFS 12'h050
`define ARB_POLICY_RST 8'h00
`define ARB_POLICY_WMASK 8'hF7
`define ARB_CTRL_RST 1'h1
`define POL_ALT_CPU_BIT 7
`define POL_FIXED_MSB 6
`define POL_FIXED_LSB 4
`define POL_ROT_MSB 2
`define POL_ROT_LSB 0
`define CTRL_GATING_BIT 7
`define CTRL_HALT_BIT 0
`define GNT_TIMEOUT_CLKS 5'h10
`define SPECIAL_DATA_CLKS 3'h4
`define CMD_SPECIAL 4'h1
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define HALT_BE_N 4'hC
`define HALT_ADDR 32'h00000000
`define HALT_MSG 32'h00000001
`define CPU_IDX 2'h3
`define ROT_FULL 3'h7
`endif

//--- pci_arb_pkg.sv
// State types shared by the arbiter host end and the external master end
package pci_arb_pkg;
  typedef enum logic [1:0] {ARB_IDLE = 2'h0, ARB_GRANT = 2'h1, ARB_BUSY = 2'h3} arb_state_type;
  typedef enum logic [1:0] {H_IDLE = 2'h0, H_ADDR = 2'h1, H_DATA = 2'h3, H_END = 2'h2} halt_state_type;
  typedef enum logic {T_IDLE = 1'h0, T_DATA = 1'h1} tgt_state_type;
  typedef enum logic [2:0] {
    A_IDLE = 3'h0, A_REQ = 3'h1, A_ADDR = 3'h3, A_DATA = 3'h2, A_END = 3'h6
  } agt_state_type;
endpackage : pci_arb_pkg

//--- pci_bus_arbiter_host.sv
// Host end: central PCI arbiter, halt special cycle master, simple target, APB registers
//
// What this block does
// - Alternate mode grants processor every other transaction
// - Alternate mode: master finishes, then processor turn
// - Fixed priority field orders the three requesters
// - Rotation field: fixed, full rotating or hybrid
// - Policy register resets zero, bit 3 zero
// - Transaction: address phase then data phases
// - Byte enables mark valid lanes per data phase
// - Either ready deasserted adds a wait cycle
// - Writes need no turnaround after address
// - Request line answered by grant per scheme
// - Grant withdrawn without frame within 16 clocks
// - Higher priority request preempts an unused grant
// - Outside alternate mode, grant moves on once current frame starts
// - No new agent granted until buffers flushed
// - Halt instruction broadcasts a special cycle
// - Halt cycle: command 0001, then 1100, 0001h
// - Gating bit waits for processor buffers empty
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "pci_arb_consts.svh"
module pci_bus_arbiter_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor side
  input wire logic halt_exec,
  input wire logic post_buf_empty,
  input wire logic cpu_buf_empty,
  // PCI link
  pci_link_if.host_end pci
);
  pci_arb_pkg::arb_state_type arb_reg, arb_next;
  pci_arb_pkg::halt_state_type h_reg, h_next;
  pci_arb_pkg::tgt_state_type t_reg, t_next;
  logic [3:0] gnt_reg, gnt_next;
  logic [1:0] owner_reg, owner_next;
  logic [1:0] last_reg, last_next;
  logic [3:0] served_reg, served_next;
  logic turn_reg, turn_next;
  logic [4:0] timer_reg, timer_next;
  logic [2:0] hcnt_reg, hcnt_next;
  logic hpend_reg, hpend_next;
  logic t_write_reg, t_write_next;
  logic t_turn_reg, t_turn_next;
  logic frame_q_reg, frame_q_next;
  logic [31:0] tdata_reg, tdata_next;
  logic [7:0] policy_reg, policy_next;
  logic gating_reg, gating_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [3:0] req;
  logic [3:0] req_eff;
  logic [3:0] rot_mask;
  logic [3:0] elig;
  logic [2:0] sel;
  logic gate_ok;
  logic alt_cpu;
  logic bus_idle;
  logic wr_hit;
  logic t_done;

  // Priority order, highest first in the top two bits; the processor sits last
  function automatic logic [7:0] fixed_order(input logic [2:0] code);
    case (code)
      3'h1: fixed_order = {2'h0, 2'h2, 2'h1, `CPU_IDX};
      3'h4: fixed_order = {2'h1, 2'h2, 2'h0, `CPU_IDX};
      3'h6: fixed_order = {2'h2, 2'h1, 2'h0, `CPU_IDX};
      3'h7: fixed_order = {2'h2, 2'h0, 2'h1, `CPU_IDX};
      default: fixed_order = {2'h0, 2'h1, 2'h2, `CPU_IDX};
    endcase
  endfunction : fixed_order

  // Highest requester in the given order, valid flag on top
  function automatic logic [2:0] pick(input logic [3:0] r, input logic [2:0] code);
    logic [7:0] ord;
    logic [1:0] idx;
    pick = 3'h0;
    ord = fixed_order(code);
    for (int i = 0; i < 4; i++) begin
      idx = ord[2*i +: 2];
      if (r[idx]) begin
        pick = {1'b1, idx};
      end
    end
  endfunction : pick

  function automatic logic [3:0] onehot(input logic [1:0] i);
    onehot = 4'h1 << i;
  endfunction : onehot

  // Request gathering and selection
  assign alt_cpu = policy_reg[`POL_ALT_CPU_BIT];
  assign req = {hpend_reg, ~pci.req_n};
  assign bus_idle = pci.frame_n & pci.irdy_n;
  always_comb begin
    if (alt_cpu && turn_reg && req[3]) begin
      req_eff = 4'h8;
    end else if (alt_cpu && !turn_reg && (req[2:0] != 3'h0)) begin
      req_eff = {1'b0, req[2:0]};
    end else begin
      req_eff = req;
    end
  end
  assign rot_mask = {policy_reg[`POL_ROT_MSB:`POL_ROT_LSB] == `ROT_FULL,
                     policy_reg[`POL_ROT_MSB:`POL_ROT_LSB]};
  // Served rotating requesters drop below the rest until all are served
  assign elig = req_eff & ~(served_reg & rot_mask);
  assign sel = pick((elig != 4'h0) ? elig : req_eff,
                    policy_reg[`POL_FIXED_MSB:`POL_FIXED_LSB]);
  assign gate_ok = !gating_reg || cpu_buf_empty;

  // Arbiter sequencing
  always_comb begin
    arb_next = arb_reg;
    gnt_next = gnt_reg;
    owner_next = owner_reg;
    last_next = last_reg;
    served_next = ((req & rot_mask & ~served_reg) == 4'h0) ? 4'h0 : served_reg;
    turn_next = turn_reg;
    timer_next = timer_reg;
    case (arb_reg)
      pci_arb_pkg::ARB_IDLE: begin
        if (alt_cpu && turn_reg && !req[3]) begin
          turn_next = 1'b0;
        end
        if (sel[2] && gate_ok && ((sel[1:0] == last_reg) || post_buf_empty)) begin
          gnt_next = onehot(sel[1:0]);
          owner_next = sel[1:0];
          timer_next = 5'h00;
          arb_next = pci_arb_pkg::ARB_GRANT;
        end
      end
      pci_arb_pkg::ARB_GRANT: begin
        if (!pci.frame_n) begin
          served_next = served_next | (onehot(owner_reg) & rot_mask);
          last_next = owner_reg;
          arb_next = pci_arb_pkg::ARB_BUSY;
          if (owner_reg == `CPU_IDX) begin
            turn_next = 1'b0;
          end
        end else if ((timer_reg == `GNT_TIMEOUT_CLKS - 5'h01) || !req[owner_reg]) begin
          gnt_next = 4'h0;
          arb_next = pci_arb_pkg::ARB_IDLE;
        end else if (sel[2] && (sel[1:0] != owner_reg)) begin
          gnt_next = 4'h0;
          arb_next = pci_arb_pkg::ARB_IDLE;
        end else begin
          timer_next = timer_reg + 5'h01;
        end
      end
      pci_arb_pkg::ARB_BUSY: begin
        // Alternate mode parks nobody, so other requests wait for the owner to finish
        if (alt_cpu) begin
          gnt_next = 4'h0;
        end else if (sel[2] && gate_ok && post_buf_empty) begin
          gnt_next = onehot(sel[1:0]);
          owner_next = sel[1:0];
        end else begin
          gnt_next = 4'h0;
        end
        if (bus_idle) begin
          if (alt_cpu && (last_reg != `CPU_IDX)) begin
            turn_next = 1'b1;
          end
          timer_next = 5'h00;
          arb_next = (gnt_next != 4'h0) ? pci_arb_pkg::ARB_GRANT : pci_arb_pkg::ARB_IDLE;
        end
      end
      default: begin
        gnt_next = 4'h0;
        arb_next = pci_arb_pkg::ARB_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      arb_reg <= pci_arb_pkg::ARB_IDLE;
      gnt_reg <= 4'h0;
      owner_reg <= 2'h0;
      last_reg <= 2'h0;
      served_reg <= 4'h0;
      turn_reg <= 1'b0;
      timer_reg <= 5'h00;
    end else begin
      arb_reg <= arb_next;
      gnt_reg <= gnt_next;
      owner_reg <= owner_next;
      last_reg <= last_next;
      served_reg <= served_next;
      turn_reg <= turn_next;
      timer_reg <= timer_next;
    end
  end

  // Halt broadcast; a new halt arriving as the old one starts stays pending
  always_comb begin
    h_next = h_reg;
    hcnt_next = hcnt_reg;
    hpend_next = hpend_reg;
    case (h_reg)
      pci_arb_pkg::H_IDLE: begin
        if (hpend_reg && gnt_reg[`CPU_IDX] && bus_idle) begin
          hpend_next = 1'b0;
          h_next = pci_arb_pkg::H_ADDR;
        end
      end
      pci_arb_pkg::H_ADDR: begin
        hcnt_next = 3'h0;
        h_next = pci_arb_pkg::H_DATA;
      end
      pci_arb_pkg::H_DATA: begin
        // No target claims a special cycle, so the master ends it on its own count
        hcnt_next = hcnt_reg + 3'h1;
        if (hcnt_reg == `SPECIAL_DATA_CLKS - 3'h1) begin
          h_next = pci_arb_pkg::H_END;
        end
      end
      pci_arb_pkg::H_END: begin
        h_next = pci_arb_pkg::H_IDLE;
      end
      default: begin
        h_next = pci_arb_pkg::H_IDLE;
      end
    endcase
    if (halt_exec || (wr_hit && (paddr == `ARB_CTRL_OFS) && pwdata[`CTRL_HALT_BIT])) begin
      hpend_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      h_reg <= pci_arb_pkg::H_IDLE;
      hcnt_reg <= 3'h0;
      hpend_reg <= 1'b0;
    end else begin
      h_reg <= h_next;
      hcnt_reg <= hcnt_next;
      hpend_reg <= hpend_next;
    end
  end

  // Target side: claims every external transaction, reads insert a turnaround
  assign t_done = (t_reg == pci_arb_pkg::T_DATA) && !pci.irdy_n && !t_turn_reg;
  always_comb begin
    t_next = t_reg;
    t_write_next = t_write_reg;
    t_turn_next = 1'b0;
    tdata_next = tdata_reg;
    frame_q_next = pci.frame_n;
    case (t_reg)
      pci_arb_pkg::T_IDLE: begin
        if (!pci.frame_n && frame_q_reg && (h_reg == pci_arb_pkg::H_IDLE)) begin
          t_write_next = pci.cbe_n[0];
          t_turn_next = !pci.cbe_n[0];
          t_next = pci_arb_pkg::T_DATA;
        end
      end
      pci_arb_pkg::T_DATA: begin
        if (t_done) begin
          if (t_write_reg) begin
            for (int b = 0; b < 4; b++) begin
              if (!pci.cbe_n[b]) begin
                tdata_next[8*b +: 8] = pci.ad[8*b +: 8];
              end
            end
          end
          if (pci.frame_n) begin
            t_next = pci_arb_pkg::T_IDLE;
          end
        end
      end
      default: begin
        t_next = pci_arb_pkg::T_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      t_reg <= pci_arb_pkg::T_IDLE;
      t_write_reg <= 1'b0;
      t_turn_reg <= 1'b0;
      tdata_reg <= 32'h00000000;
      frame_q_reg <= 1'b1;
    end else begin
      t_reg <= t_next;
      t_write_reg <= t_write_next;
      t_turn_reg <= t_turn_next;
      tdata_reg <= tdata_next;
      frame_q_reg <= frame_q_next;
    end
  end

  // APB registers: read data is fetched in setup so the access phase needs no wait
  assign wr_hit = psel && penable && pwrite;
  always_comb begin
    policy_next = policy_reg;
    gating_next = gating_reg;
    prdata_next = prdata_reg;
    if (wr_hit && (paddr == `ARB_POLICY_OFS)) begin
      policy_next = pwdata[7:0] & `ARB_POLICY_WMASK;
    end
    if (wr_hit && (paddr == `ARB_CTRL_OFS)) begin
      gating_next = pwdata[`CTRL_GATING_BIT];
    end
    if (psel && !penable) begin
      case (paddr)
        `ARB_POLICY_OFS: prdata_next = {24'h000000, policy_reg};
        `ARB_CTRL_OFS: prdata_next = {24'h000000, gating_reg, 7'h00};
        `ARB_STATUS_OFS: prdata_next = {22'h0, turn_reg, hpend_reg, 2'h0, arb_reg, gnt_reg};
        `ARB_TDATA_OFS: prdata_next = tdata_reg;
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      policy_reg <= `ARB_POLICY_RST;
      gating_reg <= `ARB_CTRL_RST;
      prdata_reg <= 32'h00000000;
    end else begin
      policy_reg <= policy_next;
      gating_reg <= gating_next;
      prdata_reg <= prdata_next;
    end
  end

  assign pready = psel && penable;
  assign pslverr = pready && (paddr != `ARB_POLICY_OFS) && (paddr != `ARB_CTRL_OFS) &&
                   (paddr != `ARB_STATUS_OFS) && (paddr != `ARB_TDATA_OFS);
  assign prdata = prdata_reg;

  // Link drive: grants, halt cycle as master, ready and read data as target
  assign pci.gnt_n = ~gnt_reg[2:0];
  assign pci.dev_ctl_oe = (h_reg != pci_arb_pkg::H_IDLE);
  assign pci.dev_frame_n = (h_reg != pci_arb_pkg::H_ADDR);
  assign pci.dev_irdy_n = (h_reg != pci_arb_pkg::H_DATA);
  assign pci.dev_cbe_n = (h_reg == pci_arb_pkg::H_ADDR) ? `CMD_SPECIAL : `HALT_BE_N;
  assign pci.dev_ad_oe = (h_reg == pci_arb_pkg::H_ADDR) || (h_reg == pci_arb_pkg::H_DATA) ||
                         ((t_reg == pci_arb_pkg::T_DATA) && !t_write_reg && !t_turn_reg);
  assign pci.dev_ad = (h_reg == pci_arb_pkg::H_ADDR) ? `HALT_ADDR :
                      ((h_reg == pci_arb_pkg::H_DATA) ? `HALT_MSG : tdata_reg);
  assign pci.dev_trdy_oe = (t_reg == pci_arb_pkg::T_DATA);
  assign pci.dev_trdy_n = t_turn_reg;
endmodule : pci_bus_arbiter_host

//--- pci_bus_arbiter_host_chk.sv
// Concurrent checks on the shared PCI wires between the host end and the master end
`timescale 1ns/1ps
module pci_bus_arbiter_host_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Resolved link wires
  input wire logic [2:0] req_n,
  input wire logic [2:0] gnt_n,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic [3:0] cbe_n,
  input wire logic [31:0] ad
);
  logic [5:0] idle_cnt_reg;
  logic [5:0] idle_cnt_next;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Cycles a grant stands on an idle bus; drops back to zero on the cycle after it reaches 6'h3F
  always_comb begin
    idle_cnt_next = 6'h00;
    if (gnt_n != 3'h7 && frame_n && irdy_n && idle_cnt_reg != 6'h3F) begin
      idle_cnt_next = idle_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) idle_cnt_reg <= 6'h00;
    else idle_cnt_reg <= idle_cnt_next;
  end

  // Special cycle address phase, then its data phase
  sequence halt_addr_s;
    $fell(frame_n) && cbe_n == 4'h1;
  endsequence
  sequence halt_data_s;
    (!irdy_n && cbe_n == 4'hC && ad[15:0] == 16'h0001) [*4];
  endsequence

  grant_single_a: assert property ($onehot0(~gnt_n))
    else $error("more than one grant line active");
  grant_by_req_a: assert property (($changed(gnt_n) && gnt_n != 3'h7) |->
    ((~gnt_n & $past(req_n)) == 3'h0)) else $error("grant given without a request");
  grant_timeout_a: assert property (idle_cnt_reg <= 6'h14)
    else $error("unused grant not withdrawn");
  cmd_valid_a: assert property ($fell(frame_n) |-> cbe_n inside {4'h1, 4'h6, 4'h7})
    else $error("address phase without a known command");
  write_noturn_a: assert property (($fell(frame_n) && cbe_n == 4'h7) |=>
    (!irdy_n && !trdy_n)) else $error("write data phase delayed after address");
  read_turn_a: assert property (($fell(frame_n) && cbe_n == 4'h6) |=>
    trdy_n ##1 !trdy_n) else $error("read turnaround not one clock");
  halt_data_a: assert property (halt_addr_s |=> halt_data_s)
    else $error("halt data phase fields wrong");
  halt_end_a: assert property (halt_addr_s ##1 halt_data_s |=> (irdy_n && frame_n))
    else $error("halt cycle not ended");
endmodule : pci_bus_arbiter_host_chk

//--- pci_bus_arbiter_host_tb_top.sv
// Self-checking bench joining the arbiter host end to the external master end
`timescale 1ns/1ps
`include "pci_arb_consts.svh"
module pci_bus_arbiter_host_tb_top;
  typedef struct packed {logic [1:0] agent; logic wr; logic [3:0] beats; logic [31:0] data;} row_type;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic halt_exec = 1'b0;
  logic post_buf_empty = 1'b1;
  logic cpu_buf_empty = 1'b1;
  logic xfer_valid = 1'b0;
  logic [1:0] xfer_agent = 2'h0;
  logic xfer_write = 1'b0;
  logic [31:0] xfer_wdata = 32'h0;
  logic [3:0] xfer_beats = 4'h1;
  logic [3:0] xfer_be_n = 4'h0;
  logic xfer_ready;
  logic xfer_done;
  logic [31:0] xfer_rdata;
  logic [2:0] last_gnt_n = 3'h7;
  logic halt_seen = 1'b0;
  logic [31:0] rd;
  logic err;
  logic [31:0] last_wr = 32'h0;
  int num_errors = 0;
  int num_checks = 0;
  // Ordinary transfers: agent, write, beats, data; reads expect the last word written
  row_type rows [6] = '{
    '{2'h0, 1'b1, 4'h1, 32'hA5A50001}, '{2'h1, 1'b0, 4'h2, 32'h0},
    '{2'h2, 1'b1, 4'h3, 32'h5A5A0002}, '{2'h0, 1'b0, 4'h1, 32'h0},
    '{2'h1, 1'b1, 4'hF, 32'hC3C30003}, '{2'h2, 1'b0, 4'h0, 32'h0}};

  pci_link_if pci ();

  pci_bus_arbiter_host u_pci_bus_arbiter_host (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec), .post_buf_empty(post_buf_empty),
    .cpu_buf_empty(cpu_buf_empty), .pci(pci.host_end));
  // Address stays fixed; the host target claims every address alike
  pci_master_agent u_pci_master_agent (.ref_clk(ref_clk), .nrst(nrst), .xfer_valid(xfer_valid),
    .xfer_agent(xfer_agent), .xfer_write(xfer_write), .xfer_addr(32'h00001000),
    .xfer_wdata(xfer_wdata), .xfer_be_n(xfer_be_n), .xfer_beats(xfer_beats),
    .xfer_ready(xfer_ready), .xfer_done(xfer_done), .xfer_rdata(xfer_rdata),
    .pci(pci.agent_end));
  pci_bus_arbiter_host_chk u_pci_bus_arbiter_host_chk (.ref_clk(ref_clk), .nrst(nrst),
    .req_n(pci.req_n), .gnt_n(pci.gnt_n), .frame_n(pci.frame_n), .irdy_n(pci.irdy_n),
    .trdy_n(pci.trdy_n), .cbe_n(pci.cbe_n), .ad(pci.ad));

  always #2.5 ref_clk = ~ref_clk;

  // Wire monitor, sampled mid-cycle where everything has settled
  always @(negedge ref_clk) begin
    if (pci.gnt_n != 3'h7) last_gnt_n = pci.gnt_n;
    if (!pci.frame_n && pci.cbe_n === `CMD_SPECIAL && pci.dev_ctl_oe) halt_seen = 1'b1;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Only called while the engine is idle, so the order is taken at the next edge
  task automatic start_xfer(input row_type r);
    @(posedge ref_clk);
    last_gnt_n = 3'h7;
    xfer_valid <= 1'b1;
    xfer_agent <= r.agent;
    xfer_write <= r.wr;
    xfer_wdata <= r.data;
    xfer_beats <= r.beats;
    @(posedge ref_clk);
    xfer_valid <= 1'b0;
  endtask : start_xfer

  task automatic wait_done(input string name);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (xfer_done !== 1'b1 && n < 300);
    chk(name, 32'h1, {31'h0, xfer_done});
  endtask : wait_done

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, `ARB_POLICY_OFS, 32'h0);
    chk("policy reset", {24'h0, `ARB_POLICY_RST}, rd);
    apb(1'b0, `ARB_CTRL_OFS, 32'h0);
    chk("control reset", 32'h80, rd);
    apb(1'b1, 12'h100, 32'hFFFFFFFF);
    chk("unmapped write err", 32'h1, {31'h0, err});
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped read", 32'h0, rd);
    $display("reset test done");
    // Every priority and rotation code, each carrying live traffic
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `ARB_POLICY_OFS, {25'h0, i[2:0], 1'b1, i[2:0]});
      apb(1'b0, `ARB_POLICY_OFS, 32'h0);
      chk("policy", {25'h0, i[2:0], 1'b0, i[2:0]}, rd);
      start_xfer(rows[i % 6]);
      wait_done("xfer done");
      chk("grant line", {29'h0, 3'h7 & ~(3'h1 << rows[i % 6].agent)}, {29'h0, last_gnt_n});
      if (rows[i % 6].wr) begin
        last_wr = rows[i % 6].data;
        apb(1'b0, `ARB_TDATA_OFS, 32'h0);
        chk("target word", last_wr, rd);
      end else begin
        chk("read data", last_wr, xfer_rdata);
      end
    end
    $display("table test done");
    // Gating holds the grant while processor buffers are busy
    apb(1'b1, `ARB_POLICY_OFS, 32'h0);
    cpu_buf_empty <= 1'b0;
    start_xfer(rows[0]);
    repeat (20) @(negedge ref_clk);
    chk("gated grant", 32'h7, {29'h0, pci.gnt_n});
    @(posedge ref_clk);
    cpu_buf_empty <= 1'b1;
    wait_done("gated done");
    // A new agent waits for the posting buffers to flush
    @(posedge ref_clk);
    post_buf_empty <= 1'b0;
    start_xfer(rows[2]);
    repeat (20) @(negedge ref_clk);
    chk("flush grant", 32'h7, {29'h0, pci.gnt_n});
    @(posedge ref_clk);
    post_buf_empty <= 1'b1;
    wait_done("flush done");
    // Enables 1100 write only the low two lanes of the target word
    @(posedge ref_clk);
    xfer_be_n <= 4'hC;
    start_xfer(rows[0]);
    wait_done("lane done");
    apb(1'b0, `ARB_TDATA_OFS, 32'h0);
    chk("lane merge", 32'h5A5A0001, rd);
    xfer_be_n <= 4'h0;
    $display("buffer test done");
    // Halt in alternate mode alongside agent traffic
    apb(1'b1, `ARB_POLICY_OFS, 32'h80);
    halt_seen = 1'b0;
    halt_exec <= 1'b1;
    @(posedge ref_clk);
    halt_exec <= 1'b0;
    start_xfer(rows[4]);
    wait_done("alt done");
    repeat (40) @(negedge ref_clk);
    chk("halt cycle", 32'h1, {31'h0, halt_seen});
    apb(1'b0, `ARB_STATUS_OFS, 32'h0);
    chk("halt pending", 32'h0, {31'h0, rd[8]});
    $display("halt test done");
    // Reset in mid-run restores the policy
    apb(1'b1, `ARB_POLICY_OFS, 32'h77);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, `ARB_POLICY_OFS, 32'h0);
    chk("policy rerun", {24'h0, `ARB_POLICY_RST}, rd);
    $display("mid-run reset test done");
    complete_run();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    $display("watchdog expired");
    num_errors++;
    complete_run();
  end
endmodule : pci_bus_arbiter_host_tb_top

//--- pci_link_if.sv
// Shared PCI wires between the host end and the external master end
`timescale 1ns/1ps
interface pci_link_if;
  logic [2:0] req_n;
  logic [2:0] gnt_n;
  logic dev_ctl_oe;
  logic dev_ad_oe;
  logic dev_trdy_oe;
  logic dev_frame_n;
  logic dev_irdy_n;
  logic dev_trdy_n;
  logic [3:0] dev_cbe_n;
  logic [31:0] dev_ad;
  logic agt_ctl_oe;
  logic agt_ad_oe;
  logic agt_frame_n;
  logic agt_irdy_n;
  logic [3:0] agt_cbe_n;
  logic [31:0] agt_ad;
  logic frame_n;
  logic irdy_n;
  logic trdy_n;
  logic [3:0] cbe_n;
  logic [31:0] ad;

  // Wire resolution; undriven lines float high as with pull-ups
  assign frame_n = dev_ctl_oe ? dev_frame_n : (agt_ctl_oe ? agt_frame_n : 1'b1);
  assign irdy_n = dev_ctl_oe ? dev_irdy_n : (agt_ctl_oe ? agt_irdy_n : 1'b1);
  assign cbe_n = dev_ctl_oe ? dev_cbe_n : (agt_ctl_oe ? agt_cbe_n : 4'hF);
  assign ad = dev_ad_oe ? dev_ad : (agt_ad_oe ? agt_ad : 32'hFFFFFFFF);
  assign trdy_n = dev_trdy_oe ? dev_trdy_n : 1'b1;

  modport host_end (
    output gnt_n, dev_ctl_oe, dev_ad_oe, dev_trdy_oe, dev_frame_n, dev_irdy_n,
    output dev_trdy_n, dev_cbe_n, dev_ad,
    input req_n, frame_n, irdy_n, trdy_n, cbe_n, ad
  );
  modport agent_end (
    output req_n, agt_ctl_oe, agt_ad_oe, agt_frame_n, agt_irdy_n, agt_cbe_n, agt_ad,
    input gnt_n, frame_n, irdy_n, trdy_n, cbe_n, ad
  );
endinterface : pci_link_if

//--- pci_master_agent.sv
// External PCI master end: three request/grant pairs sharing one transfer engine
`timescale 1ns/1ps
`include "pci_arb_consts.svh"
module pci_master_agent (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Transfer orders
  input wire logic xfer_valid,
  input wire logic [1:0] xfer_agent,
  input wire logic xfer_write,
  input wire logic [31:0] xfer_addr,
  input wire logic [31:0] xfer_wdata,
  input wire logic [3:0] xfer_be_n,
  input wire logic [3:0] xfer_beats,
  output logic xfer_ready,
  output logic xfer_done,
  output logic [31:0] xfer_rdata,
  // PCI link
  pci_link_if.agent_end pci
);
  pci_arb_pkg::agt_state_type a_reg, a_next;
  logic [1:0] who_reg, who_next;
  logic wr_reg, wr_next;
  logic [31:0] addr_reg, addr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] be_reg, be_next;
  logic [3:0] left_reg, left_next;
  logic done_reg, done_next;
  logic [31:0] rdata_reg, rdata_next;
  logic bus_idle;

  assign bus_idle = pci.frame_n & pci.irdy_n;

  // Transfer sequencing; starts the frame on the first idle clock after grant
  always_comb begin
    a_next = a_reg;
    who_next = who_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    be_next = be_reg;
    left_next = left_reg;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    case (a_reg)
      pci_arb_pkg::A_IDLE: begin
        if (xfer_valid) begin
          who_next = (xfer_agent == 2'h3) ? 2'h2 : xfer_agent;
          wr_next = xfer_write;
          addr_next = xfer_addr;
          wdata_next = xfer_wdata;
          be_next = xfer_be_n;
          left_next = (xfer_beats == 4'h0) ? 4'h1 : xfer_beats;
          a_next = pci_arb_pkg::A_REQ;
        end
      end
      pci_arb_pkg::A_REQ: begin
        if (!pci.gnt_n[who_reg] && bus_idle) begin
          a_next = pci_arb_pkg::A_ADDR;
        end
      end
      pci_arb_pkg::A_ADDR: begin
        a_next = pci_arb_pkg::A_DATA;
      end
      pci_arb_pkg::A_DATA: begin
        if (!pci.trdy_n) begin
          rdata_next = pci.ad;
          left_next = left_reg - 4'h1;
          if (left_reg == 4'h1) begin
            done_next = 1'b1;
            a_next = pci_arb_pkg::A_END;
          end
        end
      end
      pci_arb_pkg::A_END: begin
        a_next = pci_arb_pkg::A_IDLE;
      end
      default: begin
        a_next = pci_arb_pkg::A_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      a_reg <= pci_arb_pkg::A_IDLE;
      who_reg <= 2'h0;
      wr_reg <= 1'b0;
      addr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
      be_reg <= 4'hF;
      left_reg <= 4'h0;
      done_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      a_reg <= a_next;
      who_reg <= who_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      be_reg <= be_next;
      left_reg <= left_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
    end
  end

  // Request held from order until the last data phase ends
  assign pci.req_n = ~(((a_reg == pci_arb_pkg::A_REQ) || (a_reg == pci_arb_pkg::A_ADDR) ||
                        (a_reg == pci_arb_pkg::A_DATA)) ? (3'h1 << who_reg) : 3'h0);
  // Control lines driven high for one clock after the last phase before release
  assign pci.agt_ctl_oe = (a_reg == pci_arb_pkg::A_ADDR) || (a_reg == pci_arb_pkg::A_DATA) ||
                          (a_reg == pci_arb_pkg::A_END);
  assign pci.agt_frame_n = !((a_reg == pci_arb_pkg::A_ADDR) ||
                             ((a_reg == pci_arb_pkg::A_DATA) && (left_reg != 4'h1)));
  assign pci.agt_irdy_n = (a_reg != pci_arb_pkg::A_DATA);
  assign pci.agt_cbe_n = (a_reg == pci_arb_pkg::A_ADDR) ?
                         (wr_reg ? `CMD_MEM_WRITE : `CMD_MEM_READ) : be_reg;
  // Reads release the data lines after the address so the target can turn them
  assign pci.agt_ad_oe = (a_reg == pci_arb_pkg::A_ADDR) ||
                         ((a_reg == pci_arb_pkg::A_DATA) && wr_reg);
  assign pci.agt_ad = (a_reg == pci_arb_pkg::A_ADDR) ? addr_reg : wdata_reg;
  assign xfer_ready = (a_reg == pci_arb_pkg::A_IDLE);
  assign xfer_done = done_reg;
  assign xfer_rdata = rdata_reg;
endmodule : pci_master_agent
